// ---- pam_pkg.sv ----
// Shared widths, encodings and carrier types for the program space address mapper.
package pam_pkg;

	localparam int unsigned PAM_EA_W      = 16;
	localparam int unsigned PAM_PW_W      = 24;
	localparam int unsigned PAM_DW_W      = 16;
	localparam int unsigned PAM_PAGE_W    = 8;
	localparam int unsigned PAM_BYTE_W    = 8;
	localparam int unsigned PAM_EA_TOP    = 15;
	localparam int unsigned PAM_VIS_EA_W  = 15;
	localparam int unsigned PAM_PAGE_TOP  = 7;
	localparam int unsigned PAM_PBE_W     = 3;
	localparam int unsigned PAM_DBE_W     = 2;

	localparam logic [PAM_PBE_W-1:0] PAM_PBE_NONE  = 3'h0;
	localparam logic [PAM_PBE_W-1:0] PAM_PBE_B0    = 3'h1;
	localparam logic [PAM_PBE_W-1:0] PAM_PBE_B1    = 3'h2;
	localparam logic [PAM_PBE_W-1:0] PAM_PBE_LOW   = 3'h3;
	localparam logic [PAM_PBE_W-1:0] PAM_PBE_B2    = 3'h4;
	localparam logic [PAM_DBE_W-1:0] PAM_DBE_NONE  = 2'h0;
	localparam logic [PAM_DBE_W-1:0] PAM_DBE_B0    = 2'h1;
	localparam logic [PAM_DBE_W-1:0] PAM_DBE_B1    = 2'h2;
	localparam logic [PAM_DBE_W-1:0] PAM_DBE_WORD  = 2'h3;
	localparam logic [PAM_BYTE_W-1:0] PAM_BYTE_ZERO = 8'h00;

	typedef enum logic [2:0] {
		PAM_ACC_DATA_RD,
		PAM_ACC_DATA_WR,
		PAM_ACC_TBL_RD_LO,
		PAM_ACC_TBL_RD_HI,
		PAM_ACC_TBL_WR_LO,
		PAM_ACC_TBL_WR_HI
	} pam_acc_e;

	typedef enum logic [1:0] {
		PAM_TGT_DATA,
		PAM_TGT_PROG,
		PAM_TGT_REFUSE
	} pam_tgt_e;

	typedef struct packed {
		pam_acc_e                kind;
		logic                    byte_mode;
		logic [PAM_EA_W-1:0]     effective_address;
		logic [PAM_DW_W-1:0]     wdata;
		logic [PAM_PAGE_W-1:0]   table_page_value;
		logic [PAM_PAGE_W-1:0]   visibility_page_value;
	} pam_req_s;

	typedef struct packed {
		logic                    we;
		logic                    config_sel;
		logic [PAM_PW_W-1:0]     addr;
		logic [PAM_PBE_W-1:0]    be;
		logic [PAM_PW_W-1:0]     wdata;
	} pam_prog_s;

	typedef struct packed {
		logic                    we;
		logic [PAM_EA_W-1:0]     addr;
		logic [PAM_DBE_W-1:0]    be;
		logic [PAM_DW_W-1:0]     wdata;
	} pam_data_s;

	typedef struct packed {
		logic                    err;
		logic [PAM_DW_W-1:0]     rdata;
	} pam_rsp_s;

endpackage : pam_pkg

// ---- pam_addr_calc.sv ----
// Combinational address construction for table, visibility and plain data accesses.
module pam_addr_calc
	import pam_pkg::*;
(
	input  wire pam_req_s            req_i,
	output pam_tgt_e                 target_o,
	output logic                     config_sel_o,
	output logic [PAM_PW_W-1:0]      prog_addr_o,
	output logic [PAM_EA_W-1:0]      data_addr_o
);

	logic                  is_table;
	logic                  ea_top;
	logic [PAM_PW_W-1:0]   raw_addr;

	assign is_table = (req_i.kind != PAM_ACC_DATA_RD) && (req_i.kind != PAM_ACC_DATA_WR);
	assign ea_top   = req_i.effective_address[PAM_EA_TOP];

	always_comb begin
		target_o     = PAM_TGT_DATA;
		config_sel_o = 1'b0;
		raw_addr     = '0;
		if (is_table) begin
			target_o     = PAM_TGT_PROG;
			raw_addr     = {req_i.table_page_value, req_i.effective_address};
			config_sel_o = req_i.table_page_value[PAM_PAGE_TOP];
		end else if (ea_top) begin
			if (req_i.kind == PAM_ACC_DATA_WR) begin
				target_o = PAM_TGT_REFUSE;
			end else begin
				target_o = PAM_TGT_PROG;
			end
			raw_addr     = {1'b0, req_i.visibility_page_value,
				req_i.effective_address[PAM_VIS_EA_W-1:0]};
			config_sel_o = 1'b0;
		end else begin
			target_o = PAM_TGT_DATA;
		end
	end

	// Word addresses stay even; the low address bit selects the byte lane instead.
	assign prog_addr_o = {raw_addr[PAM_PW_W-1:1], 1'b0};
	assign data_addr_o = {req_i.effective_address[PAM_EA_W-1:1], 1'b0};

endmodule : pam_addr_calc

// ---- pam_mapper.sv ----
// Top level of the program space address mapper: request handling, lanes and memory ports.
module pam_mapper
	import pam_pkg::*;
(
	input  wire logic                clk_sys_i,
	input  wire logic                reset_i,
	input  wire logic                req_valid_i,
	output logic                     req_ready_o,
	input  wire pam_req_s            req_i,
	output logic                     rsp_valid_o,
	output pam_rsp_s                 rsp_o,
	output logic                     prog_req_o,
	output pam_prog_s                prog_o,
	input  wire logic                prog_ack_i,
	input  wire logic [PAM_PW_W-1:0] prog_rdata_i,
	output logic                     data_req_o,
	output pam_data_s                data_o,
	input  wire logic                data_ack_i,
	input  wire logic [PAM_DW_W-1:0] data_rdata_i
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PROG,
		ST_DATA,
		ST_RESP
	} pam_state_e;

	pam_state_e             state_q;
	pam_state_e             state_d;
	pam_tgt_e               target;
	logic                   config_sel;
	logic [PAM_PW_W-1:0]    prog_addr;
	logic [PAM_EA_W-1:0]    data_addr;
	logic                   accept;
	logic                   lane_hi;
	logic [PAM_BYTE_W-1:0]  wbyte;
	logic [PAM_PBE_W-1:0]   prog_be;
	logic [PAM_PW_W-1:0]    prog_wdata;
	logic                   prog_we;
	logic [PAM_DBE_W-1:0]   data_be;
	logic [PAM_DW_W-1:0]    data_wdata;
	logic                   data_we;
	pam_acc_e               kind_q;
	logic                   byte_q;
	logic                   lane_hi_q;
	logic [PAM_DW_W-1:0]    prog_lane;
	logic [PAM_DW_W-1:0]    data_lane;
	logic                   prog_start;
	logic                   data_start;
	logic                   refuse_start;

	pam_addr_calc u_addr_calc (
		.req_i        (req_i),
		.target_o     (target),
		.config_sel_o (config_sel),
		.prog_addr_o  (prog_addr),
		.data_addr_o  (data_addr)
	);

	assign req_ready_o = (state_q == ST_IDLE);
	assign accept      = req_valid_i && req_ready_o;
	assign lane_hi     = req_i.effective_address[0];
	assign wbyte       = req_i.wdata[PAM_BYTE_W-1:0];
	assign prog_start   = accept && (target == PAM_TGT_PROG);
	assign data_start   = accept && (target == PAM_TGT_DATA);
	assign refuse_start = accept && (target == PAM_TGT_REFUSE);

	// Program side byte enables and write data placement.
	always_comb begin
		prog_be    = PAM_PBE_LOW;
		prog_wdata = '0;
		prog_we    = 1'b0;
		case (req_i.kind)
			PAM_ACC_TBL_WR_LO: begin
				prog_we = 1'b1;
				if (!req_i.byte_mode) begin
					prog_be    = PAM_PBE_LOW;
					prog_wdata = {PAM_BYTE_ZERO, req_i.wdata};
				end else if (lane_hi) begin
					prog_be    = PAM_PBE_B1;
					prog_wdata = {PAM_BYTE_ZERO, wbyte, PAM_BYTE_ZERO};
				end else begin
					prog_be    = PAM_PBE_B0;
					prog_wdata = {PAM_BYTE_ZERO, PAM_BYTE_ZERO, wbyte};
				end
			end
			PAM_ACC_TBL_WR_HI: begin
				prog_we    = 1'b1;
				prog_wdata = {wbyte, PAM_BYTE_ZERO, PAM_BYTE_ZERO};
				// The odd byte of the upper word does not exist, so it writes nothing.
				if (req_i.byte_mode && lane_hi) begin
					prog_be = PAM_PBE_NONE;
				end else begin
					prog_be = PAM_PBE_B2;
				end
			end
			PAM_ACC_TBL_RD_HI: begin
				prog_be = PAM_PBE_B2;
			end
			PAM_ACC_TBL_RD_LO: begin
				prog_be = PAM_PBE_LOW;
			end
			PAM_ACC_DATA_RD: begin
				prog_be = PAM_PBE_LOW;
			end
			default: begin
				prog_be = PAM_PBE_LOW;
			end
		endcase
	end

	// Data side byte enables and write data placement.
	always_comb begin
		data_we    = (req_i.kind == PAM_ACC_DATA_WR);
		data_be    = PAM_DBE_WORD;
		data_wdata = req_i.wdata;
		if (req_i.byte_mode && lane_hi) begin
			data_be    = PAM_DBE_B1;
			data_wdata = {wbyte, wbyte};
		end else if (req_i.byte_mode) begin
			data_be    = PAM_DBE_B0;
			data_wdata = {wbyte, wbyte};
		end else begin
			data_be    = PAM_DBE_WORD;
			data_wdata = req_i.wdata;
		end
	end

	// Request sequencing: one access is in flight at a time.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (accept) begin
					case (target)
						PAM_TGT_PROG: begin
							state_d = ST_PROG;
						end
						PAM_TGT_DATA: begin
							state_d = ST_DATA;
						end
						default: begin
							state_d = ST_RESP;
						end
					endcase
				end
			end
			ST_PROG: begin
				if (prog_ack_i) begin
					state_d = ST_RESP;
				end
			end
			ST_DATA: begin
				if (data_ack_i) begin
					state_d = ST_RESP;
				end
			end
			ST_RESP: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Attributes of the accepted access, kept for steering the read lanes.
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			kind_q    <= PAM_ACC_DATA_RD;
			byte_q    <= 1'b0;
			lane_hi_q <= 1'b0;
		end else if (accept) begin
			kind_q    <= req_i.kind;
			byte_q    <= req_i.byte_mode;
			lane_hi_q <= lane_hi;
		end
	end

	// Program memory request: a one-cycle strobe, fields held until the acknowledge.
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			prog_req_o        <= 1'b0;
			prog_o.we         <= 1'b0;
			prog_o.config_sel <= 1'b0;
			prog_o.addr       <= '0;
			prog_o.be         <= PAM_PBE_NONE;
			prog_o.wdata      <= '0;
		end else begin
			prog_req_o <= prog_start;
			if (prog_start) begin
				prog_o.we         <= prog_we;
				prog_o.config_sel <= config_sel;
				prog_o.addr       <= prog_addr;
				prog_o.be         <= prog_be;
				prog_o.wdata      <= prog_wdata;
			end
		end
	end

	// Data memory request: a one-cycle strobe, fields held until the acknowledge.
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			data_req_o   <= 1'b0;
			data_o.we    <= 1'b0;
			data_o.addr  <= '0;
			data_o.be    <= PAM_DBE_NONE;
			data_o.wdata <= '0;
		end else begin
			data_req_o <= data_start;
			if (data_start) begin
				data_o.we    <= data_we;
				data_o.addr  <= data_addr;
				data_o.be    <= data_be;
				data_o.wdata <= data_wdata;
			end
		end
	end

	// Read lane selection from the returned program word.
	always_comb begin
		prog_lane = prog_rdata_i[PAM_DW_W-1:0];
		case (kind_q)
			PAM_ACC_TBL_RD_HI: begin
				if (byte_q && lane_hi_q) begin
					prog_lane = '0;
				end else begin
					prog_lane = {PAM_BYTE_ZERO, prog_rdata_i[PAM_PW_W-1:PAM_DW_W]};
				end
			end
			PAM_ACC_TBL_RD_LO,
			PAM_ACC_DATA_RD: begin
				if (byte_q && lane_hi_q) begin
					prog_lane = {PAM_BYTE_ZERO, prog_rdata_i[PAM_DW_W-1:PAM_BYTE_W]};
				end else if (byte_q) begin
					prog_lane = {PAM_BYTE_ZERO, prog_rdata_i[PAM_BYTE_W-1:0]};
				end else begin
					prog_lane = prog_rdata_i[PAM_DW_W-1:0];
				end
			end
			default: begin
				prog_lane = '0;
			end
		endcase
	end

	// Read lane selection from the returned data word.
	always_comb begin
		data_lane = data_rdata_i;
		if (byte_q && lane_hi_q) begin
			data_lane = {PAM_BYTE_ZERO, data_rdata_i[PAM_DW_W-1:PAM_BYTE_W]};
		end else if (byte_q) begin
			data_lane = {PAM_BYTE_ZERO, data_rdata_i[PAM_BYTE_W-1:0]};
		end else begin
			data_lane = data_rdata_i;
		end
	end

	// Response: read data is captured with the acknowledge and presented one cycle.
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rsp_o.err   <= 1'b0;
			rsp_o.rdata <= '0;
		end else if (refuse_start) begin
			rsp_o.err   <= 1'b1;
			rsp_o.rdata <= '0;
		end else if ((state_q == ST_PROG) && prog_ack_i) begin
			rsp_o.err   <= 1'b0;
			rsp_o.rdata <= prog_o.we ? '0 : prog_lane;
		end else if ((state_q == ST_DATA) && data_ack_i) begin
			rsp_o.err   <= 1'b0;
			rsp_o.rdata <= data_o.we ? '0 : data_lane;
		end
	end

	assign rsp_valid_o = (state_q == ST_RESP);

endmodule : pam_mapper

// ---- pam_mapper_monitor.sv ----
// Port checker of the program space address mapper.
module pam_mapper_monitor
	import pam_pkg::*;
(
	input wire logic      clk_sys_i,
	input wire logic      reset_i,
	input wire logic      req_valid_i,
	input wire logic      req_ready_o,
	input wire pam_req_s  req_i,
	input wire logic      rsp_valid_o,
	input wire pam_rsp_s  rsp_o,
	input wire logic      prog_req_o,
	input wire pam_prog_s prog_o,
	input wire logic      data_req_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	logic acc;
	assign acc = req_valid_i && req_ready_o;
	AST_TBL_ADDR: assert property (prog_req_o && $past(req_i.kind) != PAM_ACC_DATA_RD
		|-> prog_o.addr[23:1] == {$past(req_i.table_page_value), $past(req_i.effective_address[15:1])})
		else $error("table address wrong");
	AST_TBL_CFG: assert property (prog_req_o && $past(req_i.kind) != PAM_ACC_DATA_RD
		|-> prog_o.config_sel == $past(req_i.table_page_value[7])) else $error("table space wrong");
	AST_VIS_ADDR: assert property (prog_req_o && $past(req_i.kind) == PAM_ACC_DATA_RD
		|-> prog_o.addr[23:1] == {1'b0, $past(req_i.visibility_page_value),
		$past(req_i.effective_address[14:1])}) else $error("window address wrong");
	AST_VIS_USER: assert property (prog_req_o && $past(req_i.kind) == PAM_ACC_DATA_RD
		|-> !prog_o.config_sel && !prog_o.we) else $error("window left user memory");
	AST_VIS_GO: assert property (acc && req_i.kind == PAM_ACC_DATA_RD && req_i.effective_address[15]
		|=> prog_req_o && !data_req_o) else $error("window read not redirected");
	AST_DATA_STAY: assert property (acc && req_i.kind inside {PAM_ACC_DATA_RD, PAM_ACC_DATA_WR}
		&& !req_i.effective_address[15] |=> data_req_o && !prog_req_o) else $error("data access moved");
	AST_VIS_WR: assert property (acc && req_i.kind == PAM_ACC_DATA_WR && req_i.effective_address[15]
		|=> rsp_valid_o && rsp_o.err && !prog_req_o && !data_req_o) else $error("window write taken");
	AST_READY: assert property (acc |=> !req_ready_o) else $error("second request taken");
endmodule : pam_mapper_monitor

bind pam_mapper pam_mapper_monitor u_mon (.clk_sys_i, .reset_i, .req_valid_i, .req_ready_o, .req_i,
	.rsp_valid_o, .rsp_o, .prog_req_o, .prog_o, .data_req_o);

// ---- pam_mem_model.sv ----
// Program and data memory responder behind the mapper.
module pam_mem_model
	import pam_pkg::*;
(
	input  wire logic           clk_sys_i,
	input  wire logic           reset_i,
	input  wire logic           slow_i,
	input  wire logic           prog_req_i,
	input  wire pam_prog_s      prog_i,
	output logic                prog_ack_o,
	output logic [PAM_PW_W-1:0] prog_rdata_o,
	input  wire logic           data_req_i,
	input  wire pam_data_s      data_i,
	output logic                data_ack_o,
	output logic [PAM_DW_W-1:0] data_rdata_o
);
	logic [2:0]          pw_q;
	logic [2:0]          dw_q;
	logic [PAM_PW_W-1:0] pv_q;
	logic [PAM_DW_W-1:0] dv_q;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			pw_q <= 3'h0;
			dw_q <= 3'h0;
			pv_q <= 24'h0;
			dv_q <= 16'h0;
		end else begin
			pw_q <= prog_req_i ? (slow_i ? 3'h4 : 3'h1) : pw_q - {2'h0, pw_q != 3'h0};
			dw_q <= data_req_i ? (slow_i ? 3'h4 : 3'h1) : dw_q - {2'h0, dw_q != 3'h0};
			if (prog_req_i) begin
				pv_q <= prog_i.addr ^ 24'hC3A55A;
			end
			if (data_req_i) begin
				dv_q <= data_i.addr ^ 16'h3CC3;
			end
		end
	end
	// Read lines show the inverse outside the answer cycle.
	assign prog_ack_o = pw_q == 3'h1;
	assign data_ack_o = dw_q == 3'h1;
	assign prog_rdata_o = prog_ack_o ? pv_q : ~pv_q;
	assign data_rdata_o = data_ack_o ? dv_q : ~dv_q;
endmodule : pam_mem_model

// ---- pam_mapper_bench.sv ----
// Self-checking bench of the program space address mapper.
module pam_mapper_bench
	import pam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i, reset_i, req_valid_i, req_ready_o, rsp_valid_o, slow;
	logic prog_req_o, prog_ack_i, data_req_o, data_ack_i;
	pam_req_s            req_i;
	pam_rsp_s            rsp_o, rsp;
	pam_prog_s           prog_o, lp;
	pam_data_s           data_o, ld;
	logic [PAM_PW_W-1:0] prog_rdata_i, e;
	logic [PAM_DW_W-1:0] data_rdata_i;
	int                  error_cnt = 0, compares = 0, nprog = 0, n;
	pam_mapper u_pam_mapper (.clk_sys_i, .reset_i, .req_valid_i, .req_ready_o, .req_i,
		.rsp_valid_o, .rsp_o, .prog_req_o, .prog_o, .prog_ack_i, .prog_rdata_i,
		.data_req_o, .data_o, .data_ack_i, .data_rdata_i);
	pam_mem_model u_pam_mem_model (.clk_sys_i, .reset_i, .slow_i(slow), .prog_req_i(prog_req_o),
		.prog_i(prog_o), .prog_ack_o(prog_ack_i), .prog_rdata_o(prog_rdata_i),
		.data_req_i(data_req_o), .data_i(data_o), .data_ack_o(data_ack_i),
		.data_rdata_o(data_rdata_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(negedge clk_sys_i) begin
		if (prog_req_o === 1'b1) begin
			lp = prog_o;
			nprog++;
		end
		if (data_req_o === 1'b1) begin
			ld = data_o;
		end
	end
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", s, x, g);
		end
	endtask : chk
	task automatic go(input pam_acc_e k, input logic [15:0] ea, input logic [15:0] wd,
		input logic [7:0] tp, input logic [7:0] vp, input logic bm, input logic sl);
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		req_i <= '{k, bm, ea, wd, tp, vp};
		slow <= sl;
		@(negedge clk_sys_i);
		chk("ready", req_ready_o, 1'b1);
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		repeat (20) begin
			@(negedge clk_sys_i);
			if (rsp_valid_o === 1'b1) break;
		end
		chk("rsp", rsp_valid_o, 1'b1);
		rsp = rsp_o;
	endtask : go
	task automatic sc_table();
		go(PAM_ACC_TBL_RD_LO, 16'h3457, 16'h0, 8'h12, 8'h0, 1'b0, 1'b0);
		e = 24'h123456 ^ 24'hC3A55A;
		chk("t_addr", lp.addr, 24'h123456);
		chk("t_lo", rsp.rdata, e[15:0]);
		go(PAM_ACC_TBL_RD_LO, 16'h3457, 16'h0, 8'h12, 8'h0, 1'b1, 1'b0);
		chk("t_lo_b", rsp.rdata, {8'h0, e[15:8]});
		go(PAM_ACC_TBL_RD_HI, 16'hFFFE, 16'h0, 8'h85, 8'h0, 1'b0, 1'b1);
		e = 24'h85FFFE ^ 24'hC3A55A;
		chk("t_cfg", {lp.config_sel, lp.addr}, 25'h185FFFE);
		chk("t_hi", rsp.rdata, {8'h0, e[23:16]});
		go(PAM_ACC_TBL_RD_HI, 16'h0011, 16'h0, 8'h01, 8'h0, 1'b1, 1'b0);
		chk("t_hi_ph", rsp.rdata, 16'h0000);
		go(PAM_ACC_TBL_WR_LO, 16'h0201, 16'h00AB, 8'h07, 8'h0, 1'b1, 1'b0);
		chk("tw_lo", {lp.we, lp.be, lp.addr}, {1'b1, PAM_PBE_B1, 24'h070200});
		chk("tw_lo_d", lp.wdata[15:8], 8'hAB);
		go(PAM_ACC_TBL_WR_HI, 16'h0010, 16'h005C, 8'h01, 8'h0, 1'b0, 1'b0);
		chk("tw_hi", {lp.be, lp.wdata[23:16]}, {PAM_PBE_B2, 8'h5C});
		go(PAM_ACC_TBL_WR_HI, 16'h0011, 16'h0077, 8'h01, 8'h0, 1'b1, 1'b0);
		chk("tw_ph", lp.be, PAM_PBE_NONE);
	endtask : sc_table
	task automatic sc_window();
		go(PAM_ACC_DATA_RD, 16'hC001, 16'h0, 8'h0, 8'hFF, 1'b0, 1'b1);
		e = 24'h7FC000 ^ 24'hC3A55A;
		chk("v_addr", {lp.config_sel, lp.addr}, 25'h07FC000);
		chk("v_rd", rsp.rdata, e[15:0]);
		go(PAM_ACC_DATA_RD, 16'h8003, 16'h0, 8'h0, 8'h01, 1'b1, 1'b0);
		e = 24'h008002 ^ 24'hC3A55A;
		chk("v_page", lp.addr, 24'h008002);
		chk("v_rd_b", rsp.rdata, {8'h0, e[15:8]});
		n = nprog;
		go(PAM_ACC_DATA_WR, 16'h9000, 16'h1234, 8'h0, 8'h02, 1'b0, 1'b0);
		chk("v_wr", {rsp.err, rsp.rdata}, 17'h10000);
		chk("v_wr_mem", nprog, n);
	endtask : sc_window
	task automatic sc_data();
		n = nprog;
		go(PAM_ACC_DATA_RD, 16'h1235, 16'h0, 8'h80, 8'h80, 1'b0, 1'b1);
		chk("d_addr", ld.addr, 16'h1234);
		chk("d_rd", rsp.rdata, 16'h1234 ^ 16'h3CC3);
		go(PAM_ACC_DATA_RD, 16'h1235, 16'h0, 8'h0, 8'h0, 1'b1, 1'b0);
		chk("d_rd_b", rsp.rdata, (16'h1234 ^ 16'h3CC3) >> 8);
		go(PAM_ACC_DATA_WR, 16'h0020, 16'hBEEF, 8'h0, 8'h0, 1'b0, 1'b0);
		chk("d_wr", {ld.we, ld.be, ld.wdata}, {1'b1, PAM_DBE_WORD, 16'hBEEF});
		go(PAM_ACC_DATA_WR, 16'h0041, 16'h00C7, 8'h0, 8'h0, 1'b1, 1'b0);
		chk("d_wr_b", {ld.addr, ld.be, ld.wdata}, {16'h0040, PAM_DBE_B1, 16'hC7C7});
		chk("d_prog", nprog, n);
	endtask : sc_data
	task automatic final_report();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		reset_i = 1'b1;
		req_valid_i = 1'b0;
		req_i = '0;
		slow = 1'b0;
		repeat (16) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		sc_table();
		sc_window();
		sc_data();
		final_report();
	end
	// The tests need under a hundred cycles; 40000 cycles means a hang.
	initial begin
		#2000000;
		error_cnt++;
		final_report();
	end
endmodule : pam_mapper_bench
